// >>> mon_pkg.sv
// Shared constants for the monitor command decoder and its controller.
package mon_pkg;
  // ----------------------------------------
  // Message layout
  // ----------------------------------------
  localparam logic [3:0] ops_channel_class = 4'h0;
  localparam logic [3:0] error_indication_class = 4'h1;
  localparam logic [3:0] overhead_bit_class = 4'h2;
  localparam logic [3:0] local_function_class = 4'h8;
  localparam logic [3:0] direct_register_class = 4'hc;
  localparam logic [2:0] addr_terminating = 3'h0;
  localparam logic [2:0] addr_broadcast = 3'h7;
  localparam int msg_bits = 16;
  localparam logic [3:0] bit_cnt_last = 4'hf;
  // ----------------------------------------
  // Operations-channel codes and the local full-loopback code
  // ----------------------------------------
  localparam logic [7:0] hold_code = 8'h00;
  localparam logic [7:0] full_loopback_code = 8'h50;
  localparam logic [7:0] first_channel_loopback_code = 8'h51;
  localparam logic [7:0] second_channel_loopback_code = 8'h52;
  localparam logic [7:0] request_corrupt_crc_code = 8'h53;
  localparam logic [7:0] notify_corrupt_crc_code = 8'h54;
  localparam logic [7:0] unable_to_comply_code = 8'haa;
  localparam logic [7:0] return_to_normal_code = 8'hff;
  localparam logic [7:0] local_full_loopback_code = 8'h50;
  // ----------------------------------------
  // Controller APB register map
  // ----------------------------------------
  localparam logic [7:0] reg_cmd = 8'h00;
  localparam logic [7:0] reg_status = 8'h04;
  localparam logic [7:0] reg_reply = 8'h08;
  localparam logic [31:0] reset_word = 32'h0000_0000;
endpackage

// >>> mon_link_if.sv
// Serial monitor-channel link between the controller and the device.
`timescale 1ns/1ps
interface mon_link_if;
  logic din;
  logic dout;
  modport device (input din, output dout);
  modport controller (output din, input dout);
endinterface

// >>> mon_shift.sv
// Sixteen-bit serial framer: start bit low, then sixteen bits MSB first, idle high.
`timescale 1ns/1ps
module mon_shift (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  // Transmit side
  input wire logic tx_valid_in,
  input wire logic [15:0] tx_word_in,
  output logic tx_ready_out,
  output logic ser_out,
  // Receive side
  input wire logic ser_in,
  output logic rx_valid_out,
  output logic [15:0] rx_word_out
);
  logic s1_q;
  logic s2_q;
  logic tx_busy_q;
  logic [4:0] tx_cnt_q;
  logic [16:0] tx_sh_q;
  logic rx_busy_q;
  logic [3:0] rx_cnt_q;
  logic [15:0] rx_sh_q;

  assign tx_ready_out = !tx_busy_q;
  assign ser_out = tx_busy_q ? tx_sh_q[16] : 1'b1;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      tx_busy_q <= 1'b0;
      tx_cnt_q <= 5'h00;
      tx_sh_q <= 17'h1ffff;
    end else if (!tx_busy_q && tx_valid_in) begin
      tx_busy_q <= 1'b1;
      tx_cnt_q <= 5'h10;
      tx_sh_q <= {1'b0, tx_word_in};
    end else if (tx_busy_q) begin
      tx_sh_q <= {tx_sh_q[15:0], 1'b1};
      tx_cnt_q <= tx_cnt_q - 5'h01;
      if (tx_cnt_q == 5'h00) begin
        tx_busy_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
    end else begin
      s1_q <= ser_in;
      s2_q <= s1_q;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      rx_busy_q <= 1'b0;
      rx_cnt_q <= 4'h0;
      rx_sh_q <= 16'h0000;
      rx_valid_out <= 1'b0;
      rx_word_out <= 16'h0000;
    end else begin
      rx_valid_out <= 1'b0;
      if (!rx_busy_q) begin
        if (!s2_q) begin
          rx_busy_q <= 1'b1;
          rx_cnt_q <= 4'h0;
        end
      end else begin
        rx_sh_q <= {rx_sh_q[14:0], s2_q};
        rx_cnt_q <= rx_cnt_q + 4'h1;
        if (rx_cnt_q == mon_pkg::bit_cnt_last) begin
          rx_busy_q <= 1'b0;
          rx_valid_out <= 1'b1;
          rx_word_out <= {rx_sh_q[14:0], s2_q};
        end
      end
    end
  end
endmodule

// >>> mon_device.sv
// Device end: decodes monitor commands, applies operations-channel functions, replies.
//
// Contract
// - Registers reached only by two-byte monitor commands.
// - First nibble selects the message class.
// - Direct register commands answered before all others.
// - Nibble 0000, address, data flag, code.
// - Commands only set internal channel registers.
// - Sent once; device keeps the code latched.
// - Commands on input pin, confirmations on output.
// - Channel replies outrank overhead and local messages.
// - Exactly eight channel codes decoded distinctly.
// - Hold code changes no state.
// - Hold reply for bad address or data flag.
// - Full loopback waits for loopback done or local loopback command.
// - First-channel code loops first bearer channel.
// - Second-channel code loops second bearer channel.
// - Request-corrupt sends inverted CRC, stops far counter.
// - Notify-corrupt stops near counters, holds errors.
// - Undefined code answered with unable-to-comply.
// - Return-to-normal releases all, resets to FF.
// - Valid command acknowledged by unchanged echo.
`timescale 1ns/1ps
module mon_device (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  // Monitor link
  mon_link_if.device link,
  // Messages waiting from other classes
  input wire logic reg_reply_req_in,
  input wire logic [15:0] reg_reply_in,
  input wire logic ovh_req_in,
  input wire logic [15:0] ovh_msg_in,
  input wire logic loc_req_in,
  input wire logic [15:0] loc_msg_in,
  output logic reg_reply_ack_out,
  output logic ovh_ack_out,
  output logic loc_ack_out,
  // Decoded commands for other classes
  output logic reg_cmd_out,
  output logic ovh_cmd_out,
  output logic loc_cmd_out,
  output logic [15:0] cmd_word_out,
  // Channel function state
  input wire logic loopback_done_in,
  output logic [7:0] ops_code_out,
  output logic loop_request_indication_out,
  output logic alternate_loop_indication_out,
  output logic full_loop_out,
  output logic first_loop_out,
  output logic second_loop_out,
  output logic crc_invert_out,
  output logic far_counter_stop_out,
  output logic near_counter_stop_out,
  output logic error_hold_out,
  input wire logic transparent_in
);
  logic rx_valid;
  logic [15:0] rx_word;
  logic tx_ready;
  logic tx_valid;
  logic [15:0] tx_word;
  logic ops_pend_q;
  logic [15:0] ops_reply_q;
  logic full_wait_q;
  logic [3:0] cls;
  logic addr_ok;
  logic [7:0] code;
  logic defined;

  mon_shift u_shift (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .tx_valid_in(tx_valid),
    .tx_word_in(tx_word),
    .tx_ready_out(tx_ready),
    .ser_out(link.dout),
    .ser_in(link.din),
    .rx_valid_out(rx_valid),
    .rx_word_out(rx_word)
  );

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  assign cls = rx_word[15:12];
  assign addr_ok = (rx_word[11:9] == mon_pkg::addr_terminating || rx_word[11:9] == mon_pkg::addr_broadcast)
    && rx_word[8];
  assign code = rx_word[7:0];
  always_comb begin
    unique case (code)
      mon_pkg::hold_code, mon_pkg::full_loopback_code, mon_pkg::first_channel_loopback_code,
      mon_pkg::second_channel_loopback_code, mon_pkg::request_corrupt_crc_code,
      mon_pkg::notify_corrupt_crc_code, mon_pkg::unable_to_comply_code,
      mon_pkg::return_to_normal_code: defined = 1'b1;
      default: defined = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      reg_cmd_out <= 1'b0;
      ovh_cmd_out <= 1'b0;
      loc_cmd_out <= 1'b0;
      cmd_word_out <= 16'h0000;
    end else begin
      reg_cmd_out <= rx_valid && cls == mon_pkg::direct_register_class;
      ovh_cmd_out <= rx_valid && cls == mon_pkg::overhead_bit_class;
      loc_cmd_out <= rx_valid && cls == mon_pkg::local_function_class;
      if (rx_valid) begin
        cmd_word_out <= rx_word;
      end
    end
  end

  // ----------------------------------------
  // Channel function registers
  // ----------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      ops_code_out <= mon_pkg::return_to_normal_code;
      full_wait_q <= 1'b0;
      full_loop_out <= 1'b0;
      first_loop_out <= 1'b0;
      second_loop_out <= 1'b0;
      crc_invert_out <= 1'b0;
      far_counter_stop_out <= 1'b0;
      near_counter_stop_out <= 1'b0;
      error_hold_out <= 1'b0;
      loop_request_indication_out <= 1'b0;
      alternate_loop_indication_out <= 1'b0;
    end else begin
      loop_request_indication_out <= 1'b0;
      alternate_loop_indication_out <= 1'b0;
      if (full_wait_q && (loopback_done_in || (loc_cmd_out && cmd_word_out[7:0] ==
          mon_pkg::local_full_loopback_code))) begin
        full_wait_q <= 1'b0;
        full_loop_out <= 1'b1;
      end
      if (rx_valid && cls == mon_pkg::ops_channel_class && addr_ok && defined) begin
        if (code != mon_pkg::hold_code && code != mon_pkg::unable_to_comply_code) begin
          ops_code_out <= code;
        end
        unique case (code)
          mon_pkg::full_loopback_code: begin
            full_wait_q <= 1'b1;
            loop_request_indication_out <= transparent_in;
            alternate_loop_indication_out <= !transparent_in;
          end
          mon_pkg::first_channel_loopback_code: first_loop_out <= 1'b1;
          mon_pkg::second_channel_loopback_code: second_loop_out <= 1'b1;
          mon_pkg::request_corrupt_crc_code: begin
            crc_invert_out <= 1'b1;
            far_counter_stop_out <= 1'b1;
            error_hold_out <= 1'b1;
          end
          mon_pkg::notify_corrupt_crc_code: begin
            near_counter_stop_out <= 1'b1;
            error_hold_out <= 1'b1;
          end
          mon_pkg::return_to_normal_code: begin
            full_wait_q <= 1'b0;
            full_loop_out <= 1'b0;
            first_loop_out <= 1'b0;
            second_loop_out <= 1'b0;
            crc_invert_out <= 1'b0;
            far_counter_stop_out <= 1'b0;
            near_counter_stop_out <= 1'b0;
            error_hold_out <= 1'b0;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Channel reply
  // ----------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      ops_pend_q <= 1'b0;
      ops_reply_q <= 16'h0000;
    end else if (rx_valid && cls == mon_pkg::ops_channel_class) begin
      ops_pend_q <= 1'b1;
      if (!addr_ok) begin
        ops_reply_q <= {rx_word[15:8], mon_pkg::hold_code};
      end else if (!defined) begin
        ops_reply_q <= {rx_word[15:8], mon_pkg::unable_to_comply_code};
      end else begin
        ops_reply_q <= rx_word;
      end
    end else if (tx_ready && !reg_reply_req_in) begin
      ops_pend_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Reply priority
  // ----------------------------------------
  always_comb begin
    reg_reply_ack_out = 1'b0;
    ovh_ack_out = 1'b0;
    loc_ack_out = 1'b0;
    tx_valid = 1'b0;
    tx_word = 16'h0000;
    if (reg_reply_req_in) begin
      tx_valid = 1'b1;
      tx_word = reg_reply_in;
      reg_reply_ack_out = tx_ready;
    end else if (ops_pend_q) begin
      tx_valid = 1'b1;
      tx_word = ops_reply_q;
    end else if (ovh_req_in) begin
      tx_valid = 1'b1;
      tx_word = ovh_msg_in;
      ovh_ack_out = tx_ready;
    end else if (loc_req_in) begin
      tx_valid = 1'b1;
      tx_word = loc_msg_in;
      loc_ack_out = tx_ready;
    end
  end
endmodule

// >>> mon_controller.sv
// Controller end: APB slave that sends one command and captures its reply.
`timescale 1ns/1ps
module mon_controller (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Monitor link
  mon_link_if.controller link
);
  logic tx_valid_q;
  logic [15:0] tx_word_q;
  logic tx_ready;
  logic rx_valid;
  logic [15:0] rx_word;
  logic busy_q;
  logic reply_q;
  logic [15:0] reply_word_q;
  logic wr;
  logic rd;

  mon_shift u_shift (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .tx_valid_in(tx_valid_q),
    .tx_word_in(tx_word_q),
    .tx_ready_out(tx_ready),
    .ser_out(link.din),
    .ser_in(link.dout),
    .rx_valid_out(rx_valid),
    .rx_word_out(rx_word)
  );

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(paddr == mon_pkg::reg_cmd || paddr == mon_pkg::reg_status ||
    paddr == mon_pkg::reg_reply);

  // ----------------------------------------
  // Command and reply
  // ----------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      tx_valid_q <= 1'b0;
      tx_word_q <= 16'h0000;
      busy_q <= 1'b0;
    end else begin
      if (tx_valid_q && tx_ready) begin
        tx_valid_q <= 1'b0;
      end
      if (rx_valid) begin
        busy_q <= 1'b0;
      end
      if (wr && paddr == mon_pkg::reg_cmd && !busy_q) begin
        tx_valid_q <= 1'b1;
        tx_word_q <= pwdata[15:0];
        busy_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      reply_q <= 1'b0;
      reply_word_q <= 16'h0000;
    end else if (rx_valid) begin
      reply_q <= 1'b1;
      reply_word_q <= rx_word;
    end else if (rd && paddr == mon_pkg::reg_reply) begin
      reply_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      prdata <= mon_pkg::reset_word;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        mon_pkg::reg_cmd: prdata <= {16'h0000, tx_word_q};
        mon_pkg::reg_status: prdata <= {30'h0000_0000, reply_q, busy_q};
        mon_pkg::reg_reply: prdata <= {16'h0000, reply_word_q};
        default: prdata <= mon_pkg::reset_word;
      endcase
    end
  end
endmodule

// >>> mon_link_properties.sv
// Concurrent checks on the serial link between the controller and the device.
`timescale 1ns/1ps
module mon_link_properties (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic din,
  input wire logic dout
);
  logic [4:0] ic_q, oc_q;
  logic [15:0] is_q, os_q, cmd_q, rep_q;
  logic idone_q, odone_q, good, known, ops;
  // ----------------------------------------
  // Frame trackers
  // ----------------------------------------
  always_ff @(posedge core_clk_in) begin
    is_q <= {is_q[14:0], din};
    os_q <= {os_q[14:0], dout};
    if (ic_q == 5'h10) cmd_q <= {is_q[14:0], din};
    if (oc_q == 5'h10) rep_q <= {os_q[14:0], dout};
    if (reset_in) begin
      ic_q <= 5'h0;
      oc_q <= 5'h0;
      idone_q <= 1'b0;
      odone_q <= 1'b0;
    end else begin
      idone_q <= ic_q == 5'h10;
      odone_q <= oc_q == 5'h10;
      ic_q <= (ic_q == 5'h10 || (ic_q == 5'h0 && din)) ? 5'h0 : ic_q + 5'h1;
      oc_q <= (oc_q == 5'h10 || (oc_q == 5'h0 && dout)) ? 5'h0 : oc_q + 5'h1;
    end
  end
  assign good = (cmd_q[11:9] == mon_pkg::addr_terminating || cmd_q[11:9] == mon_pkg::addr_broadcast) && cmd_q[8];
  assign known = cmd_q[7:0] inside {8'h00, 8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'hff};
  assign ops = odone_q && rep_q[15:12] == mon_pkg::ops_channel_class;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  idle_after_reset_a: assert property ($fell(reset_in) |-> din && dout)
    else $error("link not idle after reset");
  din_stop_a: assert property (idone_q |-> din)
    else $error("command frame not followed by idle");
  dout_stop_a: assert property (odone_q |-> dout)
    else $error("reply frame not followed by idle");
  reply_time_a: assert property (idone_q && cmd_q[15:12] == 4'h0 |-> ##[1:60] oc_q == 5'h1)
    else $error("no reply to channel command");
  hold_reply_a: assert property (ops && !good |-> rep_q[7:0] == mon_pkg::hold_code)
    else $error("misaddressed command not answered with hold");
  unknown_code_a: assert property (ops && good && !known && cmd_q[7:0] != 8'haa |->
    rep_q[7:0] == mon_pkg::unable_to_comply_code)
    else $error("undefined code not refused");
  echo_reply_a: assert property (ops && good && known |-> rep_q == cmd_q)
    else $error("valid command not echoed");
  single_cmd_a: assert property (idone_q && cmd_q[15:12] == 4'h0 |-> din [*8])
    else $error("second command sent before reply");
endmodule

// >>> eoc_monitor_command_decoder_tb.sv
// Testbench joining the controller and device ends over the monitor link.
`timescale 1ns/1ps
module eoc_monitor_command_decoder_tb;
  logic core_clk_in, reset_in, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, ops_code_out;
  logic [31:0] pwdata, prdata, rd;
  logic reg_reply_req_in, ovh_req_in, loc_req_in, loopback_done_in, transparent_in;
  logic [15:0] reg_reply_in, ovh_msg_in, loc_msg_in, cmd_word_out;
  logic reg_reply_ack_out, ovh_ack_out, loc_ack_out, reg_cmd_out, ovh_cmd_out, loc_cmd_out;
  logic lri, ali, lri_seen, ali_seen, full_loop_out, first_loop_out, second_loop_out, crc_invert_out;
  logic far_counter_stop_out, near_counter_stop_out, error_hold_out, seen_clr;
  logic [2:0] seen;
  logic [6:0] flags;
  int fails, comparisons, stamp, t_reg, t_ovh, t_loc;
  mon_link_if link ();
  mon_device i_mon_device (.core_clk_in(core_clk_in), .reset_in(reset_in), .link(link),
    .reg_reply_req_in(reg_reply_req_in), .reg_reply_in(reg_reply_in), .ovh_req_in(ovh_req_in),
    .ovh_msg_in(ovh_msg_in), .loc_req_in(loc_req_in), .loc_msg_in(loc_msg_in),
    .reg_reply_ack_out(reg_reply_ack_out), .ovh_ack_out(ovh_ack_out), .loc_ack_out(loc_ack_out),
    .reg_cmd_out(reg_cmd_out), .ovh_cmd_out(ovh_cmd_out), .loc_cmd_out(loc_cmd_out),
    .cmd_word_out(cmd_word_out), .loopback_done_in(loopback_done_in), .ops_code_out(ops_code_out),
    .loop_request_indication_out(lri), .alternate_loop_indication_out(ali),
    .full_loop_out(full_loop_out), .first_loop_out(first_loop_out), .second_loop_out(second_loop_out),
    .crc_invert_out(crc_invert_out), .far_counter_stop_out(far_counter_stop_out),
    .near_counter_stop_out(near_counter_stop_out), .error_hold_out(error_hold_out),
    .transparent_in(transparent_in));
  mon_controller i_mon_controller (.core_clk_in(core_clk_in), .reset_in(reset_in), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link));
  mon_link_properties i_mon_link_properties (.core_clk_in(core_clk_in), .reset_in(reset_in),
    .din(link.din), .dout(link.dout));
  assign flags = {full_loop_out, first_loop_out, second_loop_out, crc_invert_out, far_counter_stop_out,
    near_counter_stop_out, error_hold_out};
  // ----------------------------------------
  // Clock, pulse capture and shared tasks
  // ----------------------------------------
  initial begin
    core_clk_in = 1'b0;
    forever #20 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in) begin
    stamp <= stamp + 1;
    if (reset_in || seen_clr) begin
      seen <= 3'h0;
      lri_seen <= 1'b0;
      ali_seen <= 1'b0;
    end else begin
      seen <= seen | {loc_cmd_out, ovh_cmd_out, reg_cmd_out};
      lri_seen <= lri_seen | lri;
      ali_seen <= ali_seen | ali;
    end
    if (reg_reply_ack_out) begin
      reg_reply_req_in <= 1'b0;
      t_reg <= stamp;
    end
    if (ovh_ack_out) begin
      ovh_req_in <= 1'b0;
      t_ovh <= stamp;
    end
    if (loc_ack_out) begin
      loc_req_in <= 1'b0;
      t_loc <= stamp;
    end
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_in);
    penable <= 1'b1;
    do begin
      @(posedge core_clk_in);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk_in);
  endtask
  task automatic do_reset();
    reset_in <= 1'b1;
    repeat (6) @(posedge core_clk_in);
    reset_in <= 1'b0;
    @(posedge core_clk_in);
  endtask
  function automatic logic [15:0] cmd(input logic [2:0] a, input logic f, input logic [7:0] c);
    return {mon_pkg::ops_channel_class, a, f, c};
  endfunction
  task automatic send(input logic [15:0] w, input logic [7:0] exp);
    apb(1'b1, mon_pkg::reg_cmd, {16'h0, w});
    do begin
      apb(1'b0, mon_pkg::reg_status, 32'h0);
    end while (rd[1] !== 1'b1);
    apb(1'b0, mon_pkg::reg_reply, 32'h0);
    check("reply word", {w[15:8], exp}, rd[15:0]);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_start();
    check("initial code", 16'hff, 16'(ops_code_out));
    apb(1'b0, 8'h0c, 32'h0);
    check("unmapped error", 16'h1, 16'(err));
  endtask
  task automatic t_functions();
    send(cmd(3'h0, 1'b1, mon_pkg::first_channel_loopback_code), 8'h51);
    check("first loop", 16'h20, 16'(flags));
    send(cmd(3'h7, 1'b1, mon_pkg::second_channel_loopback_code), 8'h52);
    check("second loop", 16'h30, 16'(flags));
    send(cmd(3'h0, 1'b1, mon_pkg::request_corrupt_crc_code), 8'h53);
    check("request corrupt", 16'h3d, 16'(flags));
    send(cmd(3'h0, 1'b1, mon_pkg::notify_corrupt_crc_code), 8'h54);
    check("notify corrupt", 16'h3f, 16'(flags));
    check("latched code", 16'h54, 16'(ops_code_out));
    send(cmd(3'h0, 1'b1, mon_pkg::hold_code), 8'h00);
    check("hold keeps state", 16'h3f54, {2'h0, flags[5:0], ops_code_out});
    send(cmd(3'h0, 1'b1, mon_pkg::return_to_normal_code), 8'hff);
    check("normal state", 16'h00ff, {1'h0, flags, ops_code_out});
  endtask
  task automatic t_refuse();
    send(cmd(3'h3, 1'b1, mon_pkg::first_channel_loopback_code), mon_pkg::hold_code);
    send(cmd(3'h0, 1'b0, mon_pkg::first_channel_loopback_code), mon_pkg::hold_code);
    check("no loop", 16'h0, 16'(flags));
    send(cmd(3'h0, 1'b1, 8'h33), mon_pkg::unable_to_comply_code);
    check("code kept", 16'hff, 16'(ops_code_out));
  endtask
  task automatic t_full_loop();
    for (int i = 0; i < 2; i++) begin
      transparent_in <= i == 0;
      seen_clr <= 1'b1;
      @(posedge core_clk_in);
      seen_clr <= 1'b0;
      send(cmd(3'h0, 1'b1, mon_pkg::full_loopback_code), 8'h50);
      check("loop held off", 16'h0, 16'(full_loop_out));
      check("indication", 16'(i == 0 ? 2'b10 : 2'b01), {14'h0, lri_seen, ali_seen});
      if (i == 0) begin
        loopback_done_in <= 1'b1;
        @(posedge core_clk_in);
        loopback_done_in <= 1'b0;
        repeat (3) @(posedge core_clk_in);
      end else begin
        apb(1'b1, mon_pkg::reg_cmd,
          {16'h0, mon_pkg::local_function_class, 4'h0, mon_pkg::local_full_loopback_code});
        repeat (40) @(posedge core_clk_in);
      end
      check("loop closed", 16'h1, 16'(full_loop_out));
      if (i == 1) begin
        do_reset();
      end
      send(cmd(3'h0, 1'b1, mon_pkg::return_to_normal_code), 8'hff);
    end
  endtask
  task automatic t_priority();
    int n;
    n = 0;
    reg_reply_req_in <= 1'b1;
    ovh_req_in <= 1'b1;
    loc_req_in <= 1'b1;
    @(posedge core_clk_in);
    while (loc_req_in && n < 300) begin
      @(posedge core_clk_in);
      n++;
    end
    check("register reply first", 16'h1, 16'(t_reg < t_ovh && t_reg < t_loc));
    check("overhead before local", 16'h1, 16'(t_ovh < t_loc));
  endtask
  task automatic t_classes();
    logic [3:0] cls [3];
    cls = '{mon_pkg::direct_register_class, mon_pkg::overhead_bit_class, mon_pkg::local_function_class};
    for (int i = 0; i < 3; i++) begin
      do_reset();
      apb(1'b1, mon_pkg::reg_cmd, {16'h0, cls[i], 12'h0a5});
      repeat (40) @(posedge core_clk_in);
      check("class pulse", 16'(3'h1 << i), 16'(seen));
      check("class word", {cls[i], 12'h0a5}, cmd_word_out);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #400000;
    fails++;
    complete_run();
  end
  initial begin
    {reset_in, psel, penable, pwrite, reg_reply_req_in, ovh_req_in, loc_req_in} = 7'h0;
    {loopback_done_in, transparent_in, lri_seen, ali_seen, seen_clr, seen} = 8'h0;
    {paddr, pwdata} = 40'h0;
    {reg_reply_in, ovh_msg_in, loc_msg_in} = {16'hc001, 16'h2abc, 16'h8001};
    {fails, comparisons, stamp, t_reg, t_ovh, t_loc} = '0;
    do_reset();
    t_start();
    t_functions();
    t_refuse();
    t_full_loop();
    t_priority();
    t_classes();
    complete_run();
  end
endmodule
